//--- anpg_engine_model.sv
// Behavioural negotiation engine that pulses received pages and events into the bank
module anpg_engine_model
  import anpg_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Events toward the bank
  output logic o_base_page_valid,
  output anpg_pkg::anpg_base_page_t o_base_page,
  output logic o_next_page_valid,
  output logic [15:0] o_next_page_word,
  output logic o_parallel_fault,
  output logic o_np_sent
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_base_page_valid = 1'b0;
    o_base_page = 16'h0000;
    o_next_page_valid = 1'b0;
    o_next_page_word = 16'h0000;
    o_parallel_fault = 1'b0;
    o_np_sent = 1'b0;
  end

  // Kind 0 base page, 1 next page, 2 fault, 3 page sent; one-cycle pulses
  // Words turn to their inverse once dropped, so a stale capture shows up
  task automatic send(input logic [1:0] kind, input logic [15:0] word);
    begin
      @(negedge i_mclk);
      o_base_page = word;
      o_next_page_word = word;
      o_base_page_valid = (kind == 2'h0);
      o_next_page_valid = (kind == 2'h1);
      o_parallel_fault = (kind == 2'h2);
      o_np_sent = (kind == 2'h3);
      @(negedge i_mclk);
      o_base_page_valid = 1'b0;
      o_next_page_valid = 1'b0;
      o_parallel_fault = 1'b0;
      o_np_sent = 1'b0;
      o_base_page = ~word;
      o_next_page_word = ~word;
    end
  endtask
endmodule

//--- anpg_latch_flag.sv
// Latch-high status flag cleared by a read; a new event wins over the clear
module anpg_latch_flag (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Event and clear
  input wire logic i_set,
  input wire logic i_clr,
  // Flag
  output logic o_flag
);
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_flag <= 1'b0;
    else if (i_set)
      o_flag <= 1'b1;
    else if (i_clr)
      o_flag <= 1'b0;
  end
endmodule

//--- anpg_params.svh
// Register offsets, field positions, reset values and encodings of the negotiation page bank
`ifndef ANPG_PARAMS_SVH
`define ANPG_PARAMS_SVH

`define ANPG_OFS_PARTNER_BASE 5'h05
`define ANPG_OFS_EXPANSION 5'h06
`define ANPG_OFS_NP_TRANSMIT 5'h07
`define ANPG_OFS_NP_RECEIVED 5'h08
`define ANPG_OFS_GIG_CONTROL 5'h09

`define ANPG_RST_PARTNER_BASE 16'h0000
`define ANPG_RST_EXPANSION 16'h0004
`define ANPG_RST_NP_TRANSMIT 16'h2001
`define ANPG_RST_NP_RECEIVED 16'h2001
`define ANPG_RST_GIG_CONTROL 16'h0300

`define ANPG_NPTX_WR_MASK 16'hb7ff
`define ANPG_GCTL_WR_MASK 16'hff00

`define ANPG_BIT_NEXT_PAGE 15
`define ANPG_BIT_ACK 14
`define ANPG_BIT_REMOTE_FAULT 13
`define ANPG_BIT_ALTERNATING 11

`define ANPG_EXP_PAR_FAULT 4
`define ANPG_EXP_PNPC 3
`define ANPG_EXP_LNPC 2
`define ANPG_EXP_PRCV 1
`define ANPG_EXP_PANC 0

`define ANPG_ABIL_SYM_PAUSE 8'h20
`define ANPG_ABIL_ASYM_PAUSE 8'h40
`define ANPG_SEL_IEEE 5'h01

`define ANPG_GC_TEST_HI 15
`define ANPG_GC_TEST_LO 13
`define ANPG_GC_ROLE_EN 12
`define ANPG_GC_ROLE_VAL 11
`define ANPG_GC_PORT_TYPE 10
`define ANPG_GC_FDX_ADV 9
`define ANPG_GC_HDX_ADV 8

`endif

//--- anpg_pkg.sv
// Types shared by the negotiation page register bank
package anpg_pkg;

  typedef struct packed {
    logic next_page_flag;
    logic ack;
    logic remote_fault_flag;
    logic [7:0] ability_field;
    logic [4:0] selector_field;
  } anpg_base_page_t;

  typedef enum logic [2:0] {
    ANPG_TSEL_NORMAL = 3'h0,
    ANPG_TSEL_WAVEFORM = 3'h1,
    ANPG_TSEL_JITTER_MASTER = 3'h2,
    ANPG_TSEL_JITTER_SLAVE = 3'h3,
    ANPG_TSEL_DISTORTION = 3'h4,
    ANPG_TSEL_RESERVED = 3'h5,
    ANPG_TSEL_CABLE_DIAG = 3'h6,
    ANPG_TSEL_ANALOG_BIST = 3'h7
  } anpg_test_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } anpg_mgmt_req_t;

  typedef struct packed {
    logic test_active;
    logic cable_diagnostics;
    logic analog_self_test;
    logic role_forced;
    logic role_master;
    logic port_multi;
    logic gig_full_duplex_adv;
    logic gig_half_duplex_adv;
    logic local_next_page_adv;
  } anpg_gig_ctl_t;

endpackage

//--- anpg_regs.sv
// Negotiation page, expansion, next-page and gigabit control register bank
// Operation
// RULE1 - Partner base page is read-only; writes ignored, last received value returned.
// RULE2 - Partner base page loads straight from received code word fields.
// RULE3 - Bit 14 shows partner acknowledged our code word.
// RULE4 - Bit 13 shows partner remote fault indication.
// RULE5 - Ability field shows symmetric pause 00100000, asymmetric pause 01000000.
// RULE6 - Received selector must match local selector; 00001 is IEEE 802.3.
// RULE7 - Parallel detect fault latches at expansion bit 4 until expansion read.
// RULE8 - Page received latches at expansion bit 1 until expansion read.
// RULE9 - Expansion bit 3 reports partner next-page capability.
// RULE10 - Expansion bit 2 reports local next-page capability, reset 0004.
// RULE11 - Expansion bit 0 reports partner auto-negotiation capability.
// RULE12 - Next-page transmit resets 2001; bits 15,13,12,10:0 writable only.
// RULE13 - Transmit word goes out as next page, toggle bit alternating.
// RULE14 - Received next page captured read-only, same layout, reset 2001.
// RULE15 - Test select 000 normal, 001 to 100 test modes 1-4, 101 reserved.
// RULE16 - Test code 110 starts cable diagnostics, 111 starts analog self-test.
// RULE17 - Manual role enable forces role from bit 11, else ignored.
// RULE18 - Bit 10 sets port type: 0 single, 1 multi.
// RULE19 - Bit 9 advertises gigabit full duplex; forced 1 in converter mode.
// RULE20 - Bit 8 advertises gigabit half duplex; forced 1 in converter; reset 0300.
// RULE21 - Any gigabit advertisement also advertises next page in base page.
// RULE22 - Reserved bits read zero; read-only fields ignore writes.
`include "anpg_params.svh"

module anpg_regs
  import anpg_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Management register port
  input wire anpg_pkg::anpg_mgmt_req_t i_mgmt,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  // Negotiation engine events
  input wire logic i_base_page_valid,
  input wire anpg_pkg::anpg_base_page_t i_base_page,
  input wire logic i_next_page_valid,
  input wire logic [15:0] i_next_page_word,
  input wire logic i_parallel_fault,
  input wire logic i_partner_np_capable,
  input wire logic i_partner_an_capable,
  input wire logic i_local_np_capable,
  input wire logic [4:0] i_local_selector,
  input wire logic i_np_sent,
  // Mode
  input wire logic i_converter_mode,
  // Negotiation engine outputs
  output logic [15:0] o_np_tx_word,
  output logic o_selector_match,
  output logic o_sym_pause,
  output logic o_asym_pause,
  output anpg_pkg::anpg_gig_ctl_t o_gig_ctl
);
  anpg_base_page_t partner_q;
  logic [15:0] np_tx_q;
  logic [15:0] np_rx_q;
  logic [15:0] gctl_q;
  logic alt_q;
  logic par_fault_flag;
  logic prcv_flag;
  logic pnpc_q;
  logic panc_q;
  logic lnpc_q;
  logic exp_read;
  logic wr_nptx;
  logic wr_gctl;
  logic [15:0] exp_word;
  logic [15:0] gctl_eff;
  logic test_active;
  logic cable_start;
  logic bist_start;

  assign exp_read = i_mgmt.rd && (i_mgmt.addr == `ANPG_OFS_EXPANSION);
  assign wr_nptx = i_mgmt.wr && (i_mgmt.addr == `ANPG_OFS_NP_TRANSMIT);
  assign wr_gctl = i_mgmt.wr && (i_mgmt.addr == `ANPG_OFS_GIG_CONTROL);

  // Partner base page: only the receive path writes it [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      partner_q <= anpg_base_page_t'(`ANPG_RST_PARTNER_BASE);
    else if (i_base_page_valid)
      partner_q <= i_base_page;
  end

  // Flags read by the engine, registered from the stored partner page
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_selector_match <= 1'b0;
      o_sym_pause <= 1'b0;
      o_asym_pause <= 1'b0;
    end
    else
    begin
      o_selector_match <= (partner_q.selector_field == i_local_selector); // [RULE6]
      o_sym_pause <= |(partner_q.ability_field & `ANPG_ABIL_SYM_PAUSE); // [RULE5]
      o_asym_pause <= |(partner_q.ability_field & `ANPG_ABIL_ASYM_PAUSE); // [RULE5]
    end
  end

  // Sticky expansion flags; an event coinciding with the read survives it
  anpg_latch_flag u_par_fault_flag (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_set(i_parallel_fault),
    .i_clr(exp_read),
    .o_flag(par_fault_flag)
  ); // [RULE7]

  anpg_latch_flag u_prcv_flag (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_set(i_base_page_valid | i_next_page_valid),
    .i_clr(exp_read),
    .o_flag(prcv_flag)
  ); // [RULE8]

  // Capability levels tracked from the engine
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pnpc_q <= 1'b0;
      panc_q <= 1'b0;
      lnpc_q <= 1'b1;
    end
    else
    begin
      pnpc_q <= i_partner_np_capable; // [RULE9]
      panc_q <= i_partner_an_capable; // [RULE11]
      lnpc_q <= i_local_np_capable; // [RULE10]
    end
  end

  always_comb
  begin
    exp_word = 16'h0000; // [RULE22]
    exp_word[`ANPG_EXP_PAR_FAULT] = par_fault_flag; // [RULE7]
    exp_word[`ANPG_EXP_PNPC] = pnpc_q; // [RULE9]
    exp_word[`ANPG_EXP_LNPC] = lnpc_q; // [RULE10]
    exp_word[`ANPG_EXP_PRCV] = prcv_flag; // [RULE8]
    exp_word[`ANPG_EXP_PANC] = panc_q; // [RULE11]
  end

  // Next-page transmit: masked write clears bits 14 and 11 [RULE12] [RULE22]
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      np_tx_q <= `ANPG_RST_NP_TRANSMIT;
    else if (wr_nptx)
      np_tx_q <= i_mgmt.wdata & `ANPG_NPTX_WR_MASK;
  end

  // Alternating bit flips after each page sent; starts so the first page goes out as 0
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      alt_q <= 1'b0;
    else if (i_np_sent)
      alt_q <= ~alt_q; // [RULE13]
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_np_tx_word <= `ANPG_RST_NP_TRANSMIT;
    else
    begin
      o_np_tx_word <= np_tx_q; // [RULE13]
      o_np_tx_word[`ANPG_BIT_ALTERNATING] <= alt_q; // [RULE13]
    end
  end

  // Received next page, no management write path [RULE14]
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      np_rx_q <= `ANPG_RST_NP_RECEIVED;
    else if (i_next_page_valid)
      np_rx_q <= i_next_page_word; // [RULE14]
  end

  // Gigabit control, reserved low byte not stored [RULE22]
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      gctl_q <= `ANPG_RST_GIG_CONTROL; // [RULE20]
    else if (wr_gctl)
      gctl_q <= i_mgmt.wdata & `ANPG_GCTL_WR_MASK;
  end

  // Converter mode overrides the stored advertisement; stored value returns on exit
  always_comb
  begin
    gctl_eff = gctl_q;
    if (i_converter_mode)
    begin
      gctl_eff[`ANPG_GC_FDX_ADV] = 1'b1; // [RULE19]
      gctl_eff[`ANPG_GC_HDX_ADV] = 1'b1; // [RULE20]
    end
  end

  anpg_test_decode u_test_decode (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_sel(anpg_test_sel_t'(gctl_q[`ANPG_GC_TEST_HI:`ANPG_GC_TEST_LO])), // [RULE15]
    .o_test_active(test_active),
    .o_cable_start(cable_start),
    .o_bist_start(bist_start)
  ); // [RULE16]

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_gig_ctl <= '0;
    else
    begin
      o_gig_ctl.test_active <= test_active; // [RULE15]
      o_gig_ctl.cable_diagnostics <= cable_start; // [RULE16]
      o_gig_ctl.analog_self_test <= bist_start; // [RULE16]
      o_gig_ctl.role_forced <= gctl_q[`ANPG_GC_ROLE_EN]; // [RULE17]
      o_gig_ctl.role_master <= gctl_q[`ANPG_GC_ROLE_EN] & gctl_q[`ANPG_GC_ROLE_VAL]; // [RULE17]
      o_gig_ctl.port_multi <= gctl_q[`ANPG_GC_PORT_TYPE]; // [RULE18]
      o_gig_ctl.gig_full_duplex_adv <= gctl_eff[`ANPG_GC_FDX_ADV]; // [RULE19]
      o_gig_ctl.gig_half_duplex_adv <= gctl_eff[`ANPG_GC_HDX_ADV]; // [RULE20]
      o_gig_ctl.local_next_page_adv <=
        gctl_eff[`ANPG_GC_FDX_ADV] | gctl_eff[`ANPG_GC_HDX_ADV]; // [RULE21]
    end
  end

  // Read port, one cycle after the strobe; unmapped offsets return zero
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_mgmt.rd;
      if (i_mgmt.rd)
      begin
        case (i_mgmt.addr)
          `ANPG_OFS_PARTNER_BASE: o_rdata <= partner_q; // [RULE1]
          `ANPG_OFS_EXPANSION: o_rdata <= exp_word;
          `ANPG_OFS_NP_TRANSMIT: o_rdata <= {np_tx_q[15:12], alt_q, np_tx_q[10:0]};
          `ANPG_OFS_NP_RECEIVED: o_rdata <= np_rx_q;
          `ANPG_OFS_GIG_CONTROL: o_rdata <= gctl_eff;
          default: o_rdata <= 16'h0000; // [RULE22]
        endcase
      end
    end
  end

  // Partner page never changes from a write
  a_base_ro_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE1]
    (i_mgmt.wr && !i_base_page_valid) |=> $stable(partner_q))
    else $error("partner page changed on write");
  a_base_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE2]
    i_base_page_valid |=> (partner_q == $past(i_base_page)))
    else $error("partner page not loaded");
  a_ack_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE3]
    (i_base_page_valid && i_base_page.ack) |=> partner_q.ack)
    else $error("ack bit lost");
  a_fault_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE4]
    i_base_page_valid |=> (partner_q.remote_fault_flag == $past(i_base_page.remote_fault_flag)))
    else $error("remote fault bit wrong");
  a_pause_sym: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE5]
    partner_q.ability_field[5] |=> o_sym_pause)
    else $error("symmetric pause missed");
  a_pause_asym: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE5]
    partner_q.ability_field[6] |=> o_asym_pause)
    else $error("asymmetric pause missed");
  a_sel_match: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE6]
    (partner_q.selector_field != i_local_selector) |=> !o_selector_match)
    else $error("selector mismatch not seen");
  a_fault_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE7]
    (par_fault_flag && !exp_read) |=> par_fault_flag)
    else $error("fault flag dropped without read");
  a_fault_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE7]
    i_parallel_fault |=> par_fault_flag)
    else $error("fault event lost");
  a_prcv_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE8]
    (exp_read && !i_base_page_valid && !i_next_page_valid) |=> !prcv_flag)
    else $error("page flag not cleared");
  a_page_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE8]
    (i_base_page_valid || i_next_page_valid) |=> prcv_flag)
    else $error("page event lost");
  a_partner_caps: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE9] [RULE11]
    1'b1 |=> (pnpc_q == $past(i_partner_np_capable) && panc_q == $past(i_partner_an_capable)))
    else $error("partner capability not tracked");
  a_local_caps: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE10]
    1'b1 |=> (lnpc_q == $past(i_local_np_capable)))
    else $error("local next page capability not tracked");
  a_nptx_toggle: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE13]
    i_np_sent |=> ##1 (o_np_tx_word[11] != $past(o_np_tx_word[11])))
    else $error("alternating bit did not flip");
  a_nptx_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE12]
    wr_nptx |=> (np_tx_q[14] == 1'b0 && np_tx_q[11] == 1'b0))
    else $error("read-only bits written");
  a_nptx_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE12]
    wr_nptx |=> (np_tx_q[15] == $past(i_mgmt.wdata[15]) &&
      np_tx_q[13:12] == $past(i_mgmt.wdata[13:12]) && np_tx_q[10:0] == $past(i_mgmt.wdata[10:0])))
    else $error("writable next page bits not stored");
  a_nprx_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE14]
    i_next_page_valid |=> (np_rx_q == $past(i_next_page_word)))
    else $error("received next page not captured");
  a_nprx_ro: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE14]
    (i_mgmt.wr && !i_next_page_valid) |=> $stable(np_rx_q))
    else $error("received next page changed on write");
  a_test_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE15]
    (gctl_q[15:13] == 3'h0 || gctl_q[15:13] == 3'h5) |=> !test_active)
    else $error("test reported on normal or reserved code");
  a_cable_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE16]
    o_gig_ctl.cable_diagnostics |=> !o_gig_ctl.cable_diagnostics)
    else $error("cable start longer than one cycle");
  a_bist_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE16]
    o_gig_ctl.analog_self_test |=> !o_gig_ctl.analog_self_test)
    else $error("self-test start longer than one cycle");
  a_role_ignore: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE17]
    !gctl_q[12] |=> !o_gig_ctl.role_master)
    else $error("role forced while disabled");
  a_role_force: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE17]
    (gctl_q[12] && gctl_q[11]) |=> o_gig_ctl.role_master)
    else $error("master role not forced");
  a_port_type: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE18]
    1'b1 |=> (o_gig_ctl.port_multi == $past(gctl_q[10])))
    else $error("port type not passed on");
  a_conv_force: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE19] [RULE20]
    i_converter_mode |=> (o_gig_ctl.gig_full_duplex_adv && o_gig_ctl.gig_half_duplex_adv))
    else $error("converter advertisement not forced");
  a_np_adv: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE21]
    o_gig_ctl.gig_half_duplex_adv |-> o_gig_ctl.local_next_page_adv)
    else $error("next page not advertised");
  a_np_adv_full: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE21]
    o_gig_ctl.gig_full_duplex_adv |-> o_gig_ctl.local_next_page_adv)
    else $error("next page not advertised with full duplex");
  a_gctl_reserved: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE22]
    wr_gctl |=> (gctl_q[15:8] == $past(i_mgmt.wdata[15:8]) && gctl_q[7:0] == 8'h00))
    else $error("gigabit control write stored wrongly");
  a_rd_unmapped: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // [RULE22]
    (i_mgmt.rd && (i_mgmt.addr < 5'h05 || i_mgmt.addr > 5'h09)) |=> (o_rdata == 16'h0000))
    else $error("unmapped read not zero");
endmodule

//--- anpg_regs_bench.sv
// Self-checking bench for the negotiation page register bank
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module anpg_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import anpg_pkg::*;

  logic mclk, rst_b, rvalid, bpv, npv, pf, nps, pnp, pan, lnp, conv, sel_m, sym, asym;
  anpg_mgmt_req_t mgmt;
  anpg_base_page_t bp;
  anpg_gig_ctl_t gc;
  logic [15:0] rdata, npw, np_tx;
  logic [4:0] lsel;
  logic [5:0] gcs;
  int errors, n_compared, nc, nb;
  logic [15:0] rv [6] = '{16'h0000, 16'h0004, 16'h2001, 16'h2001, 16'h0300, 16'h0000};
  logic [15:0] wv [6] = '{16'h18ff, 16'h0800, 16'h1400, 16'h0200, 16'h0100, 16'h0000};
  logic [5:0] ev [6] = '{6'h30, 6'h00, 6'h28, 6'h05, 6'h03, 6'h07};

  assign gcs = {gc.role_forced, gc.role_master, gc.port_multi, gc.gig_full_duplex_adv,
    gc.gig_half_duplex_adv, gc.local_next_page_adv};

  anpg_engine_model eng (.i_mclk(mclk), .o_base_page_valid(bpv), .o_base_page(bp),
    .o_next_page_valid(npv), .o_next_page_word(npw), .o_parallel_fault(pf), .o_np_sent(nps));

  anpg_regs dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_mgmt(mgmt), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_base_page_valid(bpv), .i_base_page(bp), .i_next_page_valid(npv),
    .i_next_page_word(npw), .i_parallel_fault(pf), .i_partner_np_capable(pnp),
    .i_partner_an_capable(pan), .i_local_np_capable(lnp), .i_local_selector(lsel),
    .i_np_sent(nps), .i_converter_mode(conv), .o_np_tx_word(np_tx), .o_selector_match(sel_m),
    .o_sym_pause(sym), .o_asym_pause(asym), .o_gig_ctl(gc));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic close_out();
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    begin
      @(negedge mclk);
      mgmt = {1'b1, 1'b0, a, d};
      @(negedge mclk);
      mgmt = '0;
    end
  endtask

  // Answer is awaited a few cycles at most; a silent bank ends the run
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    int k;
    begin
      @(negedge mclk);
      mgmt = {1'b0, 1'b1, a, 16'h0000};
      @(negedge mclk);
      mgmt = '0;
      k = 0;
      while (rvalid !== 1'b1 && k < 4)
      begin
        @(negedge mclk);
        k++;
      end
      if (k == 4)
      begin
        errors++;
        $display("[ERR] %0t read never answered", $time);
        close_out();
      end
      else
        `CHK(rdata, e)
    end
  endtask

  initial
  begin
    rst_b = 1'b0;
    mgmt = '0;
    {pnp, pan, conv} = 3'h0;
    lnp = 1'b1;
    lsel = 5'h01;
    errors = 0;
    n_compared = 0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    wr(5'h05, 16'hffff);
    wr(5'h06, 16'hffff);
    wr(5'h08, 16'hffff);
    for (int i = 0; i < 6; i++)
      rd(5'(i + 5), rv[i]);
    eng.send(2'h0, 16'he401);
    wr(5'h05, 16'h0000);
    rd(5'h05, 16'he401);
    `CHK({sym, asym, sel_m}, 3'b101)
    rd(5'h06, 16'h0006);
    rd(5'h06, 16'h0004);
    eng.send(2'h0, 16'h0802);
    eng.send(2'h2, 16'h0000);
    rd(5'h05, 16'h0802);
    `CHK({sym, asym, sel_m}, 3'b010)
    rd(5'h06, 16'h0016);
    rd(5'h06, 16'h0004);
    pnp = 1'b1;
    pan = 1'b1;
    eng.send(2'h1, 16'h5abc);
    rd(5'h08, 16'h5abc);
    rd(5'h06, 16'h000f);
    rd(5'h06, 16'h000d);
    lnp = 1'b0;
    rd(5'h06, 16'h0009);
    lnp = 1'b1;
    wr(5'h07, 16'hffff);
    rd(5'h07, 16'hb7ff);
    `CHK(np_tx, 16'hb7ff)
    eng.send(2'h3, 16'h0000);
    rd(5'h07, 16'hbfff);
    `CHK(np_tx, 16'hbfff)
    eng.send(2'h3, 16'h0000);
    rd(5'h07, 16'hb7ff);
    `CHK(np_tx, 16'hb7ff)
    // Every test code in turn; start strobes must come once, and only on their own code
    for (int c = 0; c < 8; c++)
    begin
      wr(5'h09, {3'(c), 13'h0300});
      nc = 0;
      nb = 0;
      repeat (6)
      begin
        @(negedge mclk);
        if (gc.cable_diagnostics === 1'b1)
          nc++;
        if (gc.analog_self_test === 1'b1)
          nb++;
      end
      `CHK(nc, int'(c == 6))
      `CHK(nb, int'(c == 7))
      rd(5'h09, {3'(c), 13'h0300});
      `CHK(gc.test_active, (c != 0 && c != 5))
    end
    // Last entry runs in converter mode with nothing advertised in storage
    for (int i = 0; i < 6; i++)
    begin
      conv = (i == 5);
      wr(5'h09, wv[i]);
      repeat (3) @(negedge mclk);
      `CHK(gcs, ev[i])
      rd(5'h09, (wv[i] & 16'hff00) | (conv ? 16'h0300 : 16'h0000));
    end
    conv = 1'b0;
    // Reset again mid-run; partner, next-page and gigabit control registers must return to their reset values
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    rd(5'h05, 16'h0000);
    rd(5'h07, 16'h2001);
    rd(5'h08, 16'h2001);
    rd(5'h09, 16'h0300);
    `CHK(np_tx, 16'h2001)
    `CHK(gcs, 6'h07)
    close_out();
  end
endmodule

//--- anpg_test_decode.sv
// Decode of the transmitter test select into start strobes and a test-active flag
module anpg_test_decode
  import anpg_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Test select
  input wire anpg_pkg::anpg_test_sel_t i_sel,
  // Decoded
  output logic o_test_active,
  output logic o_cable_start,
  output logic o_bist_start
);
  anpg_test_sel_t sel_q;

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      sel_q <= ANPG_TSEL_NORMAL;
    else
      sel_q <= i_sel;
  end

  // Start strobes fire once on entry to a diagnostic code, not every cycle
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_test_active <= 1'b0;
      o_cable_start <= 1'b0;
      o_bist_start <= 1'b0;
    end
    else
    begin
      o_test_active <= (i_sel != ANPG_TSEL_NORMAL) && (i_sel != ANPG_TSEL_RESERVED);
      o_cable_start <= (i_sel == ANPG_TSEL_CABLE_DIAG) && (sel_q != ANPG_TSEL_CABLE_DIAG);
      o_bist_start <= (i_sel == ANPG_TSEL_ANALOG_BIST) && (sel_q != ANPG_TSEL_ANALOG_BIST);
    end
  end
endmodule
